// file: logic/scg_pkg.sv
package scg_pkg;
	// Indices into the vector of sampled pins
	localparam int PIN_SRC_25M92 = 0;
	localparam int PIN_VCXO_44M736 = 1;
	localparam int PIN_REF_8K = 2;
	localparam int PIN_REF_24M576 = 3;
	localparam int PIN_LINE_CLK = 4;
	localparam int PIN_LINE_DATA = 5;
	localparam int PIN_FR_DS3_GCLK = 6;
	localparam int PIN_FR_DS3_DATA = 7;
	localparam int PIN_FR_STS1_TX = 8;
	localparam int PIN_MUX_DS3_TX = 9;
	localparam int PIN_MAP_DS1_TX = 10;
	localparam int PIN_MUX_DS1_RX = 11;
	localparam int PIN_FR_VT_RX = 12;
	localparam int PIN_MAP_VT_TX = 13;
	localparam int NUM_PINS = 14;

	// Clock of this block, 40 MHz
	localparam int CLK_PERIOD_NS = 25;

	// VCXO steering word out of reset, mid-scale so the loop starts centred
	localparam logic [11:0] VCXO_MID = 12'h800;

	// Rate accumulators, both figures in kHz
	localparam logic [15:0] DS1_NUM = 16'h1820;
	localparam logic [15:0] DS1_DEN = 16'h6540;
	localparam logic [15:0] DS3_NUM = 16'hAEC0;
	localparam logic [15:0] DS3_DEN = 16'hCA80;

	// Nominal edges in one 8 kHz frame
	localparam logic [12:0] DS3_NOM = 13'h15D8;
	localparam logic [12:0] REF_NOM = 13'h0C00;

	// Payload pointer range and H1 flag nibbles
	localparam logic [9:0] PTR_MAX = 10'h30E;
	localparam logic [3:0] NDF_SET = 4'h9;
	localparam logic [3:0] NDF_NORM = 4'h6;

	// Jitter attenuator store
	localparam int ATT_DEPTH = 8;
	localparam logic [3:0] ATT_FULL = 4'h8;

	typedef enum logic [2:0] {
		LB_NONE,
		LB_STS1_LINE,
		LB_STS1_SYS,
		LB_DS3_LINE,
		LB_DS3_SYS,
		LB_DS1_SYS,
		LB_VT15_LINE
	} scg_loop_t;
endpackage : scg_pkg

// file: logic/scg_phase_if.sv
interface scg_phase_if;
	logic [12:0] ds3_cnt;
	logic [12:0] ref_cnt;
	logic done;
	modport det (output ds3_cnt, output ref_cnt, output done);
	modport use_side (input ds3_cnt, input ref_cnt, input done);
endinterface : scg_phase_if

// file: logic/scg_phase_det.sv
module scg_phase_det (
	input wire logic clk, // 40 MHz
	input wire logic reset, // Synchronous, active high
	input wire logic ds3_rise, // Local DS3 clock edge
	input wire logic ref_rise, // 24.576 MHz edge
	input wire logic frame_rise, // 8 kHz reference edge
	scg_phase_if.det ph // Captured counts
);
	import scg_pkg::*;

	logic [12:0] ds3_cnt_q;
	logic [12:0] ref_cnt_q;
	logic [12:0] ds3_cap_q;
	logic [12:0] ref_cap_q;
	logic done_q;

	////////////////////////////////////////////////////////////////////////
	// Each frame restarts the count, so the VCXO phase is tied to the 8 kHz
	always_ff @(posedge clk) begin
		if (reset) begin
			ds3_cnt_q <= 13'h0000;
			ref_cnt_q <= 13'h0000;
			ds3_cap_q <= 13'h0000;
			ref_cap_q <= 13'h0000;
			done_q <= 1'b0;
		end else if (frame_rise) begin
			ds3_cap_q <= ds3_cnt_q;
			ref_cap_q <= ref_cnt_q;
			ds3_cnt_q <= {12'h000, ds3_rise};
			ref_cnt_q <= {12'h000, ref_rise};
			done_q <= 1'b1;
		end else begin
			ds3_cnt_q <= ds3_cnt_q + {12'h000, ds3_rise};
			ref_cnt_q <= ref_cnt_q + {12'h000, ref_rise};
			done_q <= 1'b0;
		end
	end

	assign ph.ds3_cnt = ds3_cap_q;
	assign ph.ref_cnt = ref_cap_q;
	assign ph.done = done_q;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_frame_capture: assert property (
		frame_rise |=> done_q && ds3_cap_q == $past(ds3_cnt_q))
		else $error("frame edge did not capture the DS3 count");
endmodule : scg_phase_det

// file: logic/scg_clkgen.sv
// Contract
// - Derive the 6.176 MHz DS1 transmit clock from the 25.92 MHz source.
// - DS1 clock is gapped, averaging four times 1.544 MHz, for the mappers.
// - DS3 transmit clock is phase locked to the 8 kHz central reference.
// - Expose readable phase counts of 44.736 MHz against 24.576 MHz.
// - Software-written control word steers the 44.736 MHz VCXO frequency.
// - Attenuator takes DS3 data on framer gapped clock, emits on local clock.
// - Divide recovered 51.84 MHz line clock by eight, assembling bytes.
// - Interpret H1/H2 pointer, adjusting payload alignment to the drop clock.
// - In DS3 mode, gap the 51.84 MHz line clock into nominal 44.736 MHz.
// - De-jittered DS3 clock and data pass through here to the multiplexer.
// - Loopbacks: STS-1 line/system, DS3 line/system, DS1 system, VT1.5 line.
// - Phase reference is the 24.576 MHz clock from the link slave.
// - The link slave's 8 kHz reference keeps clocks aligned to the master.
module scg_clkgen (
	input wire logic clk, // 40 MHz
	input wire logic reset, // Synchronous, active high
	input wire logic src_25m92, // 25.92 MHz source
	input wire logic vcxo_44m736, // Local DS3 VCXO clock
	input wire logic ref_8k, // 8 kHz reference from link slave
	input wire logic ref_24m576, // 24.576 MHz from link slave
	input wire logic line_rx_clk, // Recovered 51.84 MHz line clock
	input wire logic line_rx_data, // Recovered line data
	input wire logic fr_ds3_gclk, // Framer gapped DS3 clock
	input wire logic fr_ds3_data, // Framer DS3 data
	input wire logic fr_sts1_tx, // Framer STS-1 transmit data
	input wire logic mux_ds3_tx, // Multiplexer DS3 transmit data
	input wire logic map_ds1_tx, // Mapper DS1 transmit data
	input wire logic mux_ds1_rx, // Multiplexer DS1 receive data
	input wire logic fr_vt_rx, // Framer VT1.5 drop data
	input wire logic map_vt_tx, // Mapper VT1.5 add data
	input wire logic ds3_mode, // Framer in DS3 mapping mode
	input wire scg_pkg::scg_loop_t loop_mode, // Loopback select
	input wire logic [11:0] vcxo_set, // Software VCXO steering word
	input wire logic [7:0] ptr_h1, // H1 byte
	input wire logic [7:0] ptr_h2, // H2 byte
	input wire logic ptr_vld, // H1/H2 pair valid, one cycle
	output logic ds1_tx_clk, // Gapped DS1 clock pulse
	output logic ds3_gclk, // Gapped DS3 clock pulse
	output logic [11:0] vcxo_ctrl, // VCXO control word
	output logic [12:0] ph_ds3_cnt, // DS3 edges last frame
	output logic [12:0] ph_ref_cnt, // 24.576 edges last frame
	output logic [13:0] ph_ds3_err, // DS3 count minus nominal
	output logic ph_vld, // New phase reading, one cycle
	output logic [7:0] rx_byte, // Assembled receive byte
	output logic rx_byte_vld, // Byte strobe, one cycle
	output logic [9:0] ptr_cur, // Current payload pointer
	output logic ptr_inc, // Pointer increment, one cycle
	output logic ptr_dec, // Pointer decrement, one cycle
	output logic ds3_mux_data, // DS3 data to multiplexer
	output logic ds3_mux_stb, // DS3 bit strobe to multiplexer
	output logic att_ovf, // Attenuator overflow, one cycle
	output logic line_tx_data, // STS-1 data to line unit
	output logic fr_line_rx, // Line data to framer
	output logic fr_ds3_tx, // DS3 data to framer
	output logic map_ds1_rx, // DS1 data to mapper
	output logic fr_vt_tx // VT1.5 add data to framer
);
	import scg_pkg::*;

	function automatic logic [16:0] acc_step(input logic [15:0] acc, input logic [15:0] num,
			input logic [15:0] den);
		logic [16:0] s;
		s = {1'b0, acc} + {1'b0, num};
		if (s >= {1'b0, den}) begin
			acc_step = {1'b1, 16'(s - {1'b0, den})};
		end else begin
			acc_step = {1'b0, s[15:0]};
		end
	endfunction : acc_step

	function automatic logic [2:0] popcnt5(input logic [4:0] v);
		popcnt5 = 3'({2'b00, v[0]} + v[1] + v[2] + v[3] + v[4]);
	endfunction : popcnt5

	////////////////////////////////////////////////////////////////////////
	// Pin sampling: a change counts once stages two and three agree
	logic [NUM_PINS-1:0] pins_w;
	logic [NUM_PINS-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [NUM_PINS-1:0] lvl_d;
	logic [NUM_PINS-1:0] rise_w;

	assign pins_w = {map_vt_tx, fr_vt_rx, mux_ds1_rx, map_ds1_tx, mux_ds3_tx, fr_sts1_tx,
		fr_ds3_data, fr_ds3_gclk, line_rx_data, line_rx_clk, ref_24m576, ref_8k,
		vcxo_44m736, src_25m92};
	assign lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
	assign rise_w = lvl_d & ~lvl_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= pins_w;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gapped clocks: fixed accumulator patterns, so the long-term ratio is exact
	logic [15:0] ds1_acc_q, ds3_acc_q;
	logic ds1_clk_q, ds3_clk_q;
	logic [16:0] ds1_step_w, ds3_step_w;

	assign ds1_step_w = acc_step(ds1_acc_q, DS1_NUM, DS1_DEN);
	assign ds3_step_w = acc_step(ds3_acc_q, DS3_NUM, DS3_DEN);

	always_ff @(posedge clk) begin
		if (reset) begin
			ds1_acc_q <= 16'h0000;
			ds3_acc_q <= 16'h0000;
			ds1_clk_q <= 1'b0;
			ds3_clk_q <= 1'b0;
		end else begin
			ds1_clk_q <= rise_w[PIN_SRC_25M92] & ds1_step_w[16];
			if (rise_w[PIN_SRC_25M92]) begin
				ds1_acc_q <= ds1_step_w[15:0];
			end
			ds3_clk_q <= ds3_mode & rise_w[PIN_LINE_CLK] & ds3_step_w[16];
			if (ds3_mode && rise_w[PIN_LINE_CLK]) begin
				ds3_acc_q <= ds3_step_w[15:0];
			end
		end
	end

	assign ds1_tx_clk = ds1_clk_q;
	assign ds3_gclk = ds3_clk_q;

	////////////////////////////////////////////////////////////////////////
	// Digital half of the DS3 loop
	scg_phase_if ph_if ();
	logic [11:0] vcxo_q;
	logic [13:0] err_q;
	logic [12:0] cnt3_q, cntr_q;
	logic vld_q;

	scg_phase_det u_phase (
		.clk(clk),
		.reset(reset),
		.ds3_rise(rise_w[PIN_VCXO_44M736]),
		.ref_rise(rise_w[PIN_REF_24M576]),
		.frame_rise(rise_w[PIN_REF_8K]),
		.ph(ph_if.det)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			vcxo_q <= VCXO_MID;
			err_q <= 14'h0000;
			cnt3_q <= 13'h0000;
			cntr_q <= 13'h0000;
			vld_q <= 1'b0;
		end else begin
			vcxo_q <= vcxo_set;
			vld_q <= ph_if.done;
			if (ph_if.done) begin
				cnt3_q <= ph_if.ds3_cnt;
				cntr_q <= ph_if.ref_cnt;
				err_q <= {1'b0, ph_if.ds3_cnt} - {1'b0, DS3_NOM};
			end
		end
	end

	assign vcxo_ctrl = vcxo_q;
	assign ph_ds3_cnt = cnt3_q;
	assign ph_ref_cnt = cntr_q;
	assign ph_ds3_err = err_q;
	assign ph_vld = vld_q;

	////////////////////////////////////////////////////////////////////////
	// Receive byte assembly, one byte per eight line clocks
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q, byte_q;
	logic byte_vld_q;
	logic [7:0] shift_d;

	assign shift_d = {shift_q[6:0], lvl_q[PIN_LINE_DATA]};

	always_ff @(posedge clk) begin
		if (reset) begin
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			byte_q <= 8'h00;
			byte_vld_q <= 1'b0;
		end else begin
			byte_vld_q <= rise_w[PIN_LINE_CLK] && bit_cnt_q == 3'h7;
			if (rise_w[PIN_LINE_CLK]) begin
				shift_q <= shift_d;
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (bit_cnt_q == 3'h7) begin
					byte_q <= shift_d;
				end
			end
		end
	end

	assign rx_byte = byte_q;
	assign rx_byte_vld = byte_vld_q;

	////////////////////////////////////////////////////////////////////////
	// Pointer interpreter: majority of inverted I or D bits means a justification
	logic [9:0] ptr_q, last_q;
	logic [1:0] same_q;
	logic inc_q, dec_q;
	wire [9:0] ptr_rx_w = {ptr_h1[1:0], ptr_h2};
	wire [9:0] flip_w = ptr_rx_w ^ ptr_q;
	wire [2:0] i_flip_w = popcnt5({flip_w[9], flip_w[7], flip_w[5], flip_w[3], flip_w[1]});
	wire [2:0] d_flip_w = popcnt5({flip_w[8], flip_w[6], flip_w[4], flip_w[2], flip_w[0]});
	wire norm_w = ptr_vld && ptr_h1[7:4] == NDF_NORM;
	wire inc_w = norm_w && i_flip_w >= 3'h3 && d_flip_w < 3'h3;
	wire dec_w = norm_w && d_flip_w >= 3'h3 && i_flip_w < 3'h3;
	wire legal_w = ptr_rx_w <= PTR_MAX;
	wire ndf_w = ptr_vld && ptr_h1[7:4] == NDF_SET && legal_w;
	wire third_w = norm_w && !inc_w && !dec_w && legal_w && ptr_rx_w != ptr_q
		&& ptr_rx_w == last_q && same_q == 2'h2;

	always_ff @(posedge clk) begin
		if (reset) begin
			ptr_q <= 10'h000;
			last_q <= 10'h000;
			same_q <= 2'h0;
			inc_q <= 1'b0;
			dec_q <= 1'b0;
		end else begin
			inc_q <= inc_w;
			dec_q <= dec_w;
			if (ptr_vld) begin
				last_q <= ptr_rx_w;
				same_q <= (ptr_rx_w == last_q && same_q != 2'h2) ? same_q + 2'h1 : 2'h1;
			end
			if (inc_w) begin
				ptr_q <= (ptr_q == PTR_MAX) ? 10'h000 : ptr_q + 10'h001;
			end else if (dec_w) begin
				ptr_q <= (ptr_q == 10'h000) ? PTR_MAX : ptr_q - 10'h001;
			end else if (ndf_w || third_w) begin
				ptr_q <= ptr_rx_w;
			end
		end
	end

	assign ptr_cur = ptr_q;
	assign ptr_inc = inc_q;
	assign ptr_dec = dec_q;

	////////////////////////////////////////////////////////////////////////
	// Jitter attenuator store: write on framer gaps, read on local VCXO edges
	logic att_mem_q [ATT_DEPTH];
	logic [3:0] wr_q, rd_q;
	logic att_out_q, att_stb_q, ovf_q;
	wire [3:0] fill_w = wr_q - rd_q;
	wire wr_w = rise_w[PIN_FR_DS3_GCLK] && fill_w != ATT_FULL;
	wire rd_w = rise_w[PIN_VCXO_44M736] && fill_w != 4'h0;

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_q <= 4'h0;
			rd_q <= 4'h0;
			att_out_q <= 1'b0;
			att_stb_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= rise_w[PIN_FR_DS3_GCLK] && fill_w == ATT_FULL;
			att_stb_q <= rd_w;
			if (wr_w) begin
				wr_q <= wr_q + 4'h1;
			end
			if (rd_w) begin
				rd_q <= rd_q + 4'h1;
				att_out_q <= att_mem_q[rd_q[2:0]];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wr_w) begin
			att_mem_q[wr_q[2:0]] <= lvl_q[PIN_FR_DS3_DATA];
		end
	end

	assign att_ovf = ovf_q;
	assign ds3_mux_stb = att_stb_q;

	////////////////////////////////////////////////////////////////////////
	// Loopback steering, registered so every data output comes from a flop
	logic [5:0] route_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			route_q <= 6'h00;
		end else begin
			route_q[0] <= (loop_mode == LB_STS1_LINE) ? lvl_q[PIN_LINE_DATA] : lvl_q[PIN_FR_STS1_TX];
			route_q[1] <= (loop_mode == LB_STS1_SYS) ? lvl_q[PIN_FR_STS1_TX] : lvl_q[PIN_LINE_DATA];
			route_q[2] <= (loop_mode == LB_DS3_LINE) ? att_out_q : lvl_q[PIN_MUX_DS3_TX];
			route_q[3] <= (loop_mode == LB_DS3_SYS) ? lvl_q[PIN_MUX_DS3_TX] : att_out_q;
			route_q[4] <= (loop_mode == LB_DS1_SYS) ? lvl_q[PIN_MAP_DS1_TX] : lvl_q[PIN_MUX_DS1_RX];
			route_q[5] <= (loop_mode == LB_VT15_LINE) ? lvl_q[PIN_FR_VT_RX] : lvl_q[PIN_MAP_VT_TX];
		end
	end

	assign line_tx_data = route_q[0];
	assign fr_line_rx = route_q[1];
	assign fr_ds3_tx = route_q[2];
	assign ds3_mux_data = route_q[3];
	assign map_ds1_rx = route_q[4];
	assign fr_vt_tx = route_q[5];

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_src_edge;
		rise_w[PIN_SRC_25M92] && ds1_step_w[16];
	endsequence

	a_ds1_gap_src: assert property (ds1_clk_q |-> $past(rise_w[PIN_SRC_25M92]))
		else $error("DS1 pulse without a source edge");
	a_ds1_gap_next: assert property (s_src_edge |=> ds1_clk_q)
		else $error("DS1 pulse missing after accumulator carry");
	a_ds3_gap_src: assert property (
		ds3_clk_q |-> $past(ds3_mode) && $past(rise_w[PIN_LINE_CLK]))
		else $error("DS3 pulse without a line clock edge in DS3 mode");
	a_byte_strobe: assert property (
		byte_vld_q |-> $past(bit_cnt_q) == 3'h7 && bit_cnt_q == 3'h0)
		else $error("byte strobe not on the eighth bit");
	a_ptr_inc_step: assert property (
		inc_q |-> ptr_q == (($past(ptr_q) == PTR_MAX) ? 10'h000 : $past(ptr_q) + 10'h001))
		else $error("pointer increment wrong");
	a_ptr_excl: assert property (!(inc_q && dec_q))
		else $error("pointer moved both ways");
	a_vcxo_follow: assert property ($changed(vcxo_set) |=> vcxo_q == $past(vcxo_set))
		else $error("VCXO word did not follow software");
	a_att_fill: assert property (fill_w <= ATT_FULL)
		else $error("attenuator fill beyond its depth");
	a_att_ovf: assert property (
		rise_w[PIN_FR_DS3_GCLK] && fill_w == ATT_FULL |=> ovf_q && $stable(wr_q))
		else $error("write into a full attenuator not refused");
	a_loop_line: assert property (
		loop_mode == LB_STS1_LINE |=> route_q[0] == $past(lvl_q[PIN_LINE_DATA]))
		else $error("line loopback not applied");
	a_phase_err: assert property (
		ph_if.done |=> vld_q && err_q == {1'b0, cnt3_q} - {1'b0, DS3_NOM})
		else $error("phase error not captured");
endmodule : scg_clkgen

// file: tb/scg_far_model.sv
module scg_far_model (
	input wire logic clk, // Bench clock
	input wire logic vcxo_en, // Run the local DS3 clock
	input wire logic ph_en, // Run frame and link references
	output logic src_25m92, // Source clock pin
	output logic vcxo_44m736, // DS3 VCXO pin
	output logic ref_8k, // Frame reference pin
	output logic ref_24m576, // Link reference pin
	output logic line_rx_clk, // Recovered line clock
	output logic line_rx_data, // Recovered line data
	output logic fr_ds3_gclk, // Framer gapped clock
	output logic fr_ds3_data // Framer gapped data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ck = 3'h0;
	logic [2:0] dt = 3'h0;
	int vc = 0;
	int fc = 0;
	assign {fr_ds3_gclk, line_rx_clk, src_25m92} = ck;
	assign {fr_ds3_data, line_rx_data} = dt[2:1];
	////////////////////////////////////////////////////////////////
	// Periods divide the frame, so full-frame counts are exact
	always @(posedge clk) begin
		vc <= vcxo_en ? (vc + 1) % 6 : 0;
		vcxo_44m736 <= vcxo_en && vc < 3;
		fc <= ph_en ? (fc + 1) % 600 : 0;
		ref_24m576 <= ph_en && fc % 8 < 4;
		ref_8k <= ph_en && fc < 10;
	end
	////////////////////////////////////////////////////////////////
	// Three cycles each level, or the pin samplers alias
	task automatic step(input int k, input logic b);
		dt[k] <= b;
		repeat (3) @(posedge clk);
		ck[k] <= 1'b1;
		repeat (3) @(posedge clk);
		ck[k] <= 1'b0;
	endtask : step
endmodule : scg_far_model

// file: tb/scg_clkgen_tb.sv
module scg_clkgen_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scg_pkg::*;
	localparam logic [13:0] ERR_EXP = 14'h0064 - {1'b0, DS3_NOM};
	logic clk = 0;
	logic reset = 1;
	logic vcxo_en = 0;
	logic ph_en = 0;
	logic src_25m92, vcxo_44m736, ref_8k, ref_24m576;
	logic line_rx_clk, line_rx_data, fr_ds3_gclk, fr_ds3_data;
	logic fr_sts1_tx = 0, mux_ds3_tx = 0, map_ds1_tx = 0, mux_ds1_rx = 0;
	logic fr_vt_rx = 0, map_vt_tx = 0, ds3_mode = 0, ptr_vld = 0;
	scg_loop_t loop_mode = LB_NONE;
	logic [11:0] vcxo_set = 12'h123;
	logic [7:0] ptr_h1 = 8'h00, ptr_h2 = 8'h00;
	logic ds1_tx_clk, ds3_gclk, ph_vld, rx_byte_vld, ptr_inc, ptr_dec, ds3_mux_data;
	logic ds3_mux_stb, att_ovf, line_tx_data, fr_line_rx, fr_ds3_tx, map_ds1_rx, fr_vt_tx;
	logic [11:0] vcxo_ctrl;
	logic [12:0] ph_ds3_cnt, ph_ref_cnt;
	logic [13:0] ph_ds3_err;
	logic [7:0] rx_byte;
	logic [9:0] ptr_cur;
	int failures = 0, check_count = 0;
	int n_ds1 = 0, n_ds3 = 0, n_ovf = 0, n_ph = 0, nb = 0, n_stb = 0;
	logic [31:0] rs = 32'h0000_002D;
	logic [31:0] v;
	logic [7:0] sh = 8'h00;
	logic la = 0;
	logic stb_seen = 0;
	logic [7:0] byte_q[$];
	logic att_q[$];

	scg_far_model far (.clk, .vcxo_en, .ph_en, .src_25m92, .vcxo_44m736, .ref_8k,
		.ref_24m576, .line_rx_clk, .line_rx_data, .fr_ds3_gclk, .fr_ds3_data);
	scg_clkgen dut (.clk, .reset, .src_25m92, .vcxo_44m736, .ref_8k, .ref_24m576,
		.line_rx_clk, .line_rx_data, .fr_ds3_gclk, .fr_ds3_data, .fr_sts1_tx, .mux_ds3_tx,
		.map_ds1_tx, .mux_ds1_rx, .fr_vt_rx, .map_vt_tx, .ds3_mode, .loop_mode, .vcxo_set,
		.ptr_h1, .ptr_h2, .ptr_vld, .ds1_tx_clk, .ds3_gclk, .vcxo_ctrl, .ph_ds3_cnt,
		.ph_ref_cnt, .ph_ds3_err, .ph_vld, .rx_byte, .rx_byte_vld, .ptr_cur, .ptr_inc,
		.ptr_dec, .ds3_mux_data, .ds3_mux_stb, .att_ovf, .line_tx_data, .fr_line_rx,
		.fr_ds3_tx, .map_ds1_rx, .fr_vt_tx);

	initial forever #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic report_and_stop();
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	// First bit in ends up in the byte's top bit
	task automatic lbit();
		v = rnd();
		sh = {sh[6:0], v[0]};
		nb++;
		if (nb % 8 == 0) byte_q.push_back(sh);
		far.step(1, v[0]);
	endtask : lbit

	// Pulse may land one edge either way, so collect it over three cycles
	task automatic ptr(input logic [7:0] h1, h2, input logic [11:0] e);
		logic [1:0] pl;
		pl = 2'b00;
		ptr_h1 <= h1;
		ptr_h2 <= h2;
		ptr_vld <= 1'b1;
		@(posedge clk);
		ptr_vld <= 1'b0;
		repeat (3) begin
			@(negedge clk);
			pl = pl | {ptr_inc, ptr_dec};
		end
		check("ptr", e, {pl, ptr_cur});
		@(posedge clk);
	endtask : ptr

	function automatic logic [5:0] lexp(input scg_loop_t md, input logic [5:0] p);
		logic l;
		l = line_rx_data;
		return {md == LB_STS1_LINE ? l : p[5], md == LB_STS1_SYS ? p[5] : l,
			md == LB_DS3_LINE ? la : p[4], md == LB_DS3_SYS ? p[4] : la,
			md == LB_DS1_SYS ? p[3] : p[2], md == LB_VT15_LINE ? p[1] : p[0]};
	endfunction : lexp
	////////////////////////////////////////////////////////////////
	always @(negedge clk) begin
		if (ds1_tx_clk === 1'b1) n_ds1++;
		if (ds3_gclk === 1'b1) n_ds3++;
		if (att_ovf === 1'b1) n_ovf++;
		if (stb_seen) check("ds3_mux_data", att_q.pop_front(), ds3_mux_data);
		stb_seen = ds3_mux_stb === 1'b1;
		if (stb_seen) n_stb++;
		if (rx_byte_vld === 1'b1) check("rx_byte", byte_q.pop_front(), rx_byte);
		if (ph_vld === 1'b1) begin
			// First reading spans a partial frame
			if (n_ph > 0) begin
				check("ph_ds3_cnt", 600 / 6, ph_ds3_cnt);
				check("ph_ref_cnt", 600 / 8, ph_ref_cnt);
				check("ph_ds3_err", ERR_EXP, ph_ds3_err);
			end
			n_ph++;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		wt(6);
		#1 check("vcxo_ctrl rst", VCXO_MID, vcxo_ctrl);
		check("pulses rst", 0, {ds1_tx_clk, ds3_gclk, ph_vld, rx_byte_vld, att_ovf});
		wt(6);
		reset <= 1'b0;
		repeat (8) begin
			v = rnd();
			@(posedge clk);
			vcxo_set <= v[11:0];
			@(posedge clk);
			@(negedge clk);
			check("vcxo_ctrl", v[11:0], vcxo_ctrl);
		end
		@(posedge clk);
		repeat (4) far.step(0, 1'b0);
		wt(6);
		check("ds1 early", 0, n_ds1);
		far.step(0, 1'b0);
		wt(6);
		check("ds1 fifth", 1, n_ds1);
		repeat (805) far.step(0, 1'b0);
		wt(6);
		check("ds1 per 810", 193, n_ds1);
		ds3_mode <= 1'b1;
		lbit();
		wt(6);
		check("ds3 first", 0, n_ds3);
		lbit();
		wt(6);
		check("ds3 second", 1, n_ds3);
		repeat (268) lbit();
		wt(6);
		check("ds3 per 270", 233, n_ds3);
		ds3_mode <= 1'b0;
		repeat (10) lbit();
		wt(6);
		check("ds3 off", 233, n_ds3);
		check("bytes left", 0, byte_q.size());
		ptr(8'h93, 8'h0F, 12'h000);
		ptr(8'h93, 8'h0E, {2'b00, PTR_MAX});
		ptr(8'h61, 8'hA4, 12'h800);
		ptr(8'h61, 8'h55, {2'b01, PTR_MAX});
		// Third matching arrival loads, the first two do not
		repeat (2) ptr(8'h63, 8'h0C, {2'b00, PTR_MAX});
		ptr(8'h63, 8'h0C, 12'h30C);
		repeat (9) begin
			v = rnd();
			if (att_q.size() < ATT_DEPTH) att_q.push_back(v[0]);
			if (att_q.size() < ATT_DEPTH) la = v[0];
			far.step(2, v[0]);
		end
		la = att_q[ATT_DEPTH - 1];
		wt(6);
		check("att_ovf", 1, n_ovf);
		vcxo_en <= 1'b1;
		wt(70);
		vcxo_en <= 1'b0;
		check("att drained", 0, att_q.size());
		check("att reads", ATT_DEPTH, n_stb);
		for (int i = 0; i < 14; i++) begin
			v = rnd();
			loop_mode <= scg_loop_t'(i / 2);
			{fr_sts1_tx, mux_ds3_tx, map_ds1_tx, mux_ds1_rx, fr_vt_rx, map_vt_tx} <= v[5:0];
			wt(6);
			@(negedge clk);
			check("loop", lexp(scg_loop_t'(i / 2), v[5:0]), {line_tx_data, fr_line_rx,
				fr_ds3_tx, ds3_mux_data, map_ds1_rx, fr_vt_tx});
			@(posedge clk);
		end
		vcxo_en <= 1'b1;
		ph_en <= 1'b1;
		wt(1900);
		check("phase readings", 1, n_ph >= 3);
		report_and_stop();
	end

	// Whole run is about 9000 cycles
	initial begin
		wt(20000);
		failures++;
		report_and_stop();
	end
endmodule : scg_clkgen_tb
